// >>> assc_pkg.sv
/*
 * Constants, field layouts and state types of the serial channel.
 * Assumes a 32-bit AHB-Lite register bus with one word per register.
 */
package assc_pkg;
  ////////////////////////////////////////////////////////////////////////
  // Register word indices (byte address is four times the index)
  localparam logic [2:0] ASSC_IDX_CTRL = 3'h0; // Control
  localparam logic [2:0] ASSC_IDX_BAUD = 3'h1; // Baud reload
  localparam logic [2:0] ASSC_IDX_TXD = 3'h2; // Transmit buffer
  localparam logic [2:0] ASSC_IDX_RXD = 3'h3; // Receive buffer
  localparam logic [2:0] ASSC_IDX_STAT = 3'h4; // Sticky events
  localparam logic [2:0] ASSC_IDX_MASK = 3'h5; // Event mask
  localparam logic [2:0] ASSC_IDX_LAST = 3'h5; // Highest mapped index

  // Baud generator width and value after reset
  localparam int ASSC_BRG_W = 16;
  localparam logic [15:0] ASSC_BAUD_RST = 16'h0000;

  // Frame bit counts
  localparam logic [3:0] ASSC_ASYNC_BITS = 4'ha; // Start, 8 data, stop
  localparam logic [3:0] ASSC_DATA_BITS = 4'h8; // Data bits per byte

  ////////////////////////////////////////////////////////////////////////
  // Control word, bit 0 is en
  typedef struct packed {
    logic ren;  // Receiver enable
    logic fchk; // Framing check enable
    logic loop; // Internal loopback
    logic wake; // Accept only frames with ninth bit set
    logic odd;  // Odd parity
    logic par;  // Parity in ninth bit
    logic two;  // Two stop bits
    logic nine; // Nine data bits
    logic sync; // Synchronous half duplex
    logic en;   // Channel enable
  } assc_ctrl_t;

  // Event layout of status and mask, bit 0 is tx
  typedef struct packed {
    logic ovr;  // Overrun error
    logic ferr; // Framing error
    logic perr; // Parity error
    logic rx;   // Byte received
    logic tbe;  // Transmit buffer empty
    logic tx;   // Transmission done
  } assc_evt_t;

  // Line pins
  typedef struct packed {
    logic tx_pin;   // Async data out, or sync shift clock
    logic data_out; // Sync data out
    logic data_oe;  // Sync data drive enable
  } assc_pins_t;

  typedef enum logic [1:0] {
    ASSC_TX_IDLE, ASSC_TX_ASYNC, ASSC_TX_SYNC
  } assc_tx_st_t;

  typedef enum logic [1:0] {
    ASSC_RX_IDLE, ASSC_RX_START, ASSC_RX_DATA, ASSC_RX_STOP
  } assc_rx_st_t;

  // Whole module state
  typedef struct packed {
    assc_ctrl_t ctrl;
    logic [15:0] baud;
    assc_evt_t mask;
    assc_evt_t stat;
    logic [8:0] txbuf;
    logic txfull;
    logic [8:0] rxbuf;
    logic rxfull;
    assc_tx_st_t tx_st;
    logic [15:0] tx_cnt;
    logic [3:0] tx_bits;
    logic [11:0] tx_sh;
    logic tx_ph;
    logic tx_rcv;
    assc_pins_t pins;
    assc_rx_st_t rx_st;
    logic [15:0] rx_cnt;
    logic [3:0] rx_bits;
    logic [8:0] rx_sh;
    logic rx_prev;
    logic a_vld;
    logic a_wr;
    logic [2:0] a_idx;
    logic [31:0] rdata;
  } assc_state_t;
endpackage : assc_pkg

// >>> assc_channel.sv
/*
 * Asynchronous/synchronous serial channel with AHB-Lite registers.
 * Assumes one AHB-Lite master, single word transfers, inputs already
 * synchronous to mclk.
 */
// Functional notes
// RL1: Async full duplex, sync half duplex
// RL2: Own baud generator sets bit rate
// RL3: Four separate interrupt request outputs
// RL4: Start bit, then eight or nine bits
// RL5: One or two stop bits
// RL6: Wake-up bit marks address frames
// RL7: Sync bytes, shift clock driven here
// RL8: Least significant bit first always
// RL9: Loopback routes transmit into receiver
// RL10: Parity generated and checked, error flagged
// RL11: Missing stop bit flags framing error
// RL12: Unread buffer on new byte: overrun
// RL13: Idle and stop high, start low
// RL14: Errors sticky until cleared, raise irq
`timescale 1ns/10ps
module assc_channel
  import assc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic data_in,
  output assc_pins_t pins,
  output logic [3:0] irq_vec,
  output logic irq
);
  //////////////////////////////////////////////////////////////////////////
  // State and next state
  assc_state_t s; // Registered state
  assc_state_t n; // Next state
  assc_evt_t ev; // Events of this cycle
  logic rx_line; // Receiver input after loopback
  logic dlv; // Deliver a byte to the receive buffer
  logic [8:0] dlv_w; // Byte being delivered
  logic tx_load; // Transmit buffer moves into shifter
  logic [8:0] rx_w; // Async word at stop bit
  logic ninth; // Ninth transmit bit

  // Loopback picks the own line
  always_comb begin
    if (s.ctrl.loop) begin
      rx_line = s.ctrl.sync ? s.pins.data_out : s.pins.tx_pin; // RL9
    end else begin
      rx_line = data_in;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Next state logic
  always_comb begin
    n = s;
    ev = '0;
    dlv = 1'b0;
    dlv_w = '0;
    tx_load = 1'b0;
    rx_w = s.ctrl.nine ? s.rx_sh : {1'b0, s.rx_sh[8:1]};
    ninth = s.ctrl.par ? (^s.txbuf[7:0] ^ s.ctrl.odd) : s.txbuf[8]; // RL10
    // Address phase: capture, reads answer now
    n.a_vld = hsel && hready && htrans[1];
    n.a_wr = hwrite;
    n.a_idx = haddr[4:2];
    if (n.a_vld && !hwrite) begin
      unique case (haddr[4:2])
        ASSC_IDX_CTRL: n.rdata = 32'(s.ctrl);
        ASSC_IDX_BAUD: n.rdata = 32'(s.baud);
        ASSC_IDX_TXD: n.rdata = {22'h0, s.txfull, s.txbuf};
        ASSC_IDX_RXD: begin
          n.rdata = {22'h0, s.rxfull, s.rxbuf};
          n.rxfull = 1'b0; // Read empties buffer
        end
        ASSC_IDX_STAT: begin
          n.rdata = 32'(s.stat);
          n.stat = '0; // Read clears, events below win
        end
        ASSC_IDX_MASK: n.rdata = 32'(s.mask);
        default: n.rdata = 32'h0000_0000; // Unmapped reads zero
      endcase
    end
    // Data phase writes
    if (s.a_vld && s.a_wr) begin
      unique case (s.a_idx)
        ASSC_IDX_CTRL: n.ctrl = assc_ctrl_t'(hwdata[9:0]);
        ASSC_IDX_BAUD: n.baud = hwdata[15:0]; // RL2
        ASSC_IDX_TXD: begin
          n.txbuf = hwdata[8:0];
          n.txfull = 1'b1;
        end
        ASSC_IDX_MASK: n.mask = assc_evt_t'(hwdata[5:0]);
        default: ; // Others ignore writes
      endcase
    end

    // Transmit engine, also runs sync receive
    unique case (s.tx_st)
      ASSC_TX_IDLE: begin
        n.pins.tx_pin = 1'b1; // RL13
        n.pins.data_oe = 1'b0;
        if (s.ctrl.en && s.txfull) begin
          tx_load = 1'b1;
          // A write landing now refills the buffer, it must not be lost
          n.txfull = s.a_vld && s.a_wr && (s.a_idx == ASSC_IDX_TXD);
          ev.tbe = 1'b1;
          n.tx_cnt = s.baud; // RL2
          n.tx_ph = 1'b0;
          if (s.ctrl.sync) begin
            n.tx_st = ASSC_TX_SYNC; // RL1
            n.tx_sh = {4'h0, s.txbuf[7:0]};
            n.tx_bits = ASSC_DATA_BITS; // RL7
            n.tx_rcv = s.ctrl.ren;
            n.pins.tx_pin = 1'b0; // RL7
            n.pins.data_out = s.txbuf[0]; // RL8
            n.pins.data_oe = !s.ctrl.ren;
          end else begin
            n.tx_st = ASSC_TX_ASYNC;
            n.tx_sh = s.ctrl.nine ? {2'b11, ninth, s.txbuf[7:0], 1'b0}
                                  : {3'b111, s.txbuf[7:0], 1'b0}; // RL4
            n.tx_bits = ASSC_ASYNC_BITS + {3'h0, s.ctrl.nine}
                        + {3'h0, s.ctrl.two}; // RL5
            n.pins.tx_pin = 1'b0; // RL13
          end
        end
      end
      ASSC_TX_ASYNC: begin
        if (s.tx_cnt != 16'h0000) begin
          n.tx_cnt = s.tx_cnt - 16'h0001;
        end else begin
          n.tx_cnt = s.baud;
          if (s.tx_bits == 4'h1) begin
            n.tx_st = ASSC_TX_IDLE;
            n.pins.tx_pin = 1'b1;
            ev.tx = 1'b1;
          end else begin
            n.tx_sh = {1'b1, s.tx_sh[11:1]}; // RL8
            n.pins.tx_pin = s.tx_sh[1];
            n.tx_bits = s.tx_bits - 4'h1;
          end
        end
      end
      ASSC_TX_SYNC: begin
        if (s.tx_cnt != 16'h0000) begin
          n.tx_cnt = s.tx_cnt - 16'h0001;
        end else begin
          n.tx_cnt = s.baud;
          n.tx_ph = !s.tx_ph;
          if (!s.tx_ph) begin
            // Rising shift clock samples the data line
            n.pins.tx_pin = 1'b1;
            n.rx_sh = {rx_line, s.rx_sh[8:1]}; // RL8
          end else if (s.tx_bits == 4'h1) begin
            n.tx_st = ASSC_TX_IDLE;
            n.pins.tx_pin = 1'b1;
            n.pins.data_oe = 1'b0;
            ev.tx = !s.tx_rcv;
            dlv = s.tx_rcv;
            dlv_w = {1'b0, s.rx_sh[8:1]};
          end else begin
            n.pins.tx_pin = 1'b0;
            n.tx_sh = {1'b0, s.tx_sh[11:1]};
            n.pins.data_out = s.tx_sh[1]; // RL8
            n.tx_bits = s.tx_bits - 4'h1;
          end
        end
      end
      default: n.tx_st = ASSC_TX_IDLE;
    endcase

    // Async receive engine, runs beside transmit
    n.rx_prev = rx_line;
    if (!s.ctrl.en || !s.ctrl.ren || s.ctrl.sync) begin
      n.rx_st = ASSC_RX_IDLE;
    end else begin
      unique case (s.rx_st)
        ASSC_RX_IDLE: begin
          if (s.rx_prev && !rx_line) begin // RL13
            n.rx_st = ASSC_RX_START; // RL1
            n.rx_cnt = {1'b0, s.baud[15:1]};
          end
        end
        ASSC_RX_START: begin
          if (s.rx_cnt != 16'h0000) begin
            n.rx_cnt = s.rx_cnt - 16'h0001;
          end else begin
            n.rx_cnt = s.baud;
            n.rx_bits = ASSC_DATA_BITS + {3'h0, s.ctrl.nine}; // RL4
            n.rx_st = rx_line ? ASSC_RX_IDLE : ASSC_RX_DATA;
          end
        end
        ASSC_RX_DATA: begin
          if (s.rx_cnt != 16'h0000) begin
            n.rx_cnt = s.rx_cnt - 16'h0001;
          end else begin
            n.rx_cnt = s.baud;
            n.rx_sh = {rx_line, s.rx_sh[8:1]}; // RL8
            n.rx_bits = s.rx_bits - 4'h1;
            if (s.rx_bits == 4'h1) begin
              n.rx_st = ASSC_RX_STOP;
            end
          end
        end
        ASSC_RX_STOP: begin
          if (s.rx_cnt != 16'h0000) begin
            n.rx_cnt = s.rx_cnt - 16'h0001;
          end else begin
            n.rx_st = ASSC_RX_IDLE;
            ev.ferr = s.ctrl.fchk && !rx_line; // RL11
            if (!s.ctrl.wake || rx_w[8]) begin // RL6
              dlv = 1'b1;
              dlv_w = rx_w;
              ev.perr = s.ctrl.par && (^rx_w ^ s.ctrl.odd); // RL10
            end
          end
        end
        default: n.rx_st = ASSC_RX_IDLE;
      endcase
    end

    // Delivery into receive buffer
    if (dlv) begin
      ev.ovr = n.rxfull; // RL12
      n.rxbuf = dlv_w;
      n.rxfull = 1'b1;
      ev.rx = 1'b1;
    end
    n.stat = n.stat | ev; // RL14
  end

  //////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      s <= '0;
      s.baud <= ASSC_BAUD_RST;
      s.pins.tx_pin <= 1'b1;
      s.rx_prev <= 1'b1;
    end else begin
      s <= n;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs
  assign hrdata = s.rdata;
  assign hreadyout = 1'b1; // Zero wait states
  assign hresp = 1'b0; // Always OKAY
  assign pins = s.pins;
  // Transmit, buffer empty, receive and error vectors
  assign irq_vec[0] = s.stat.tx && s.mask.tx; // RL3
  assign irq_vec[1] = s.stat.tbe && s.mask.tbe; // RL3
  assign irq_vec[2] = s.stat.rx && s.mask.rx; // RL3
  assign irq_vec[3] = |(s.stat[5:3] & s.mask[5:3]); // RL14
  assign irq = |irq_vec;

  //////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  sequence async_load;
    tx_load && !s.ctrl.sync;
  endsequence

  a_start_bit_low: assert property (async_load |=> !pins.tx_pin) // RL13
    else $error("start bit not low");
  a_idle_line_high: assert property // RL13
    (s.tx_st == ASSC_TX_IDLE && !tx_load |=> pins.tx_pin)
    else $error("idle line not high");
  // Start, data, optional ninth bit and every stop bit are counted
  a_frame_len: assert property (async_load |=> s.tx_bits == // RL5
    4'ha + {3'h0, s.ctrl.nine} + {3'h0, s.ctrl.two})
    else $error("wrong frame length");
  a_parity_gen: assert property ((async_load and // RL10
    (s.ctrl.nine && s.ctrl.par))
    |=> s.tx_sh[9] == (^$past(s.txbuf[7:0]) ^ $past(s.ctrl.odd)))
    else $error("wrong parity bit");
  a_lsb_first: assert property (async_load |=> s.tx_sh[1] == // RL8
    $past(s.txbuf[0]))
    else $error("first data bit not lsb");
  // Buffer full before delivery and not emptied by a read this cycle
  a_overrun_flag: assert property (dlv && s.rxfull && !(n.a_vld // RL12
    && !hwrite && haddr[4:2] == ASSC_IDX_RXD) |=> s.stat.ovr)
    else $error("overrun not flagged");
  a_frame_err: assert property (s.rx_st == ASSC_RX_STOP // RL11
    && s.rx_cnt == 16'h0000 && s.ctrl.fchk && !rx_line && s.ctrl.en
    && s.ctrl.ren && !s.ctrl.sync |=> s.stat.ferr)
    else $error("framing error not flagged");
  a_err_sticky: assert property (s.stat.perr && !(n.a_vld && !hwrite // RL14
    && haddr[4:2] == ASSC_IDX_STAT) |=> s.stat.perr)
    else $error("parity flag lost");
  a_err_irq: assert property ((s.stat.ferr && s.mask.ferr) // RL3
    |-> irq_vec[3] && irq)
    else $error("error irq missing");
  // A reload of zero makes the low half one cycle long
  a_sync_clock: assert property (tx_load && s.ctrl.sync // RL7
    && s.baud != 16'h0000 |=> !pins.tx_pin
    && pins.data_out == $past(s.txbuf[0]) ##1 !pins.tx_pin)
    else $error("shift clock not driven low");
endmodule : assc_channel

// >>> assc_far_end.sv
/*
 * Far-end model of the serial channel: sends async frames on the
 * receive line and decodes async and sync output of the channel.
 * Assumes its caller runs off the rising edge of mclk.
 */
`timescale 1ns/10ps
module assc_far_end (
  input wire logic mclk,
  input wire logic line_in,
  input wire logic oe,
  input wire logic d_out,
  output logic line_out
);
  ////////////////////////////////////////////////////////////////////
  // Idle line rests high, as if pulled up
  initial line_out = 1'b1;
  // Set by any wait of this model that runs out
  logic lost;
  initial lost = 1'b0;

  // Frame bits given start first, each bl cycles long
  task automatic send(input logic [11:0] f, input int nb, input int bl);
    for (int i = 0; i < nb; i++) begin
      line_out <= f[i];
      repeat (bl) @(posedge mclk);
    end
    line_out <= 1'b1;
    // One idle cycle keeps frames apart
    @(posedge mclk);
  endtask : send

  // Sync receive: next bit put on after each shift clock rise
  task automatic send_sync(input logic [7:0] b);
    logic p;
    int t;
    t = 0;
    line_out <= b[0];
    for (int i = 0; i < 8; i++) begin
      do begin
        p = line_in;
        @(negedge mclk);
        t++;
      end while (!(p === 1'b0 && line_in === 1'b1) && t < 400);
      if (!(p === 1'b0 && line_in === 1'b1)) begin
        lost = 1'b1;
      end
      if (i < 7) begin
        line_out <= b[i + 1];
      end
    end
    line_out <= 1'b1;
  endtask : send_sync

  // Wait for a start edge, then sample each bit at its middle
  task automatic grab(input int nb, input int bl, output logic [11:0] f);
    int t;
    f = 12'h000;
    t = 0;
    while (line_in !== 1'b0 && t < 400) begin
      @(negedge mclk);
      t++;
    end
    if (line_in !== 1'b0) begin
      lost = 1'b1;
    end
    repeat (bl / 2) @(negedge mclk);
    for (int i = 0; i < nb; i++) begin
      f[i] = line_in;
      repeat (bl) @(negedge mclk);
    end
  endtask : grab

  // Sync byte: data taken after each shift clock rise, bit 8 = drive
  task automatic grab_sync(output logic [11:0] f);
    logic p;
    int t;
    f = 12'h100;
    t = 0;
    for (int i = 0; i < 8; i++) begin
      do begin
        p = line_in;
        @(negedge mclk);
        t++;
      end while (!(p === 1'b0 && line_in === 1'b1) && t < 400);
      if (!(p === 1'b0 && line_in === 1'b1)) begin
        lost = 1'b1;
      end
      f[i] = d_out;
      f[8] = f[8] & oe;
    end
  endtask : grab_sync
endmodule : assc_far_end

// >>> async_sync_serial_channel_tb.sv
/*
 * Self-checking bench of the serial channel over AHB-Lite.
 * Assumes the channel answers with zero wait states.
 */
`timescale 1ns/10ps
module async_sync_serial_channel_tb;
  import assc_pkg::*;
  logic mclk, rst_b, hsel, hwrite, hready, hresp, data_in, irq, far_line;
  logic [31:0] haddr, hwdata, hrdata, x;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [3:0] irq_vec;
  logic [11:0] f;
  assc_pins_t pins;
  int n_errors, n_compared;

  // Shared data wire in sync mode
  assign data_in = pins.data_oe ? pins.data_out : far_line;

  assc_channel i_dut (.mclk(mclk), .rst_b(rst_b), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hready), .hresp(hresp), .data_in(data_in), .pins(pins),
    .irq_vec(irq_vec), .irq(irq));
  assc_far_end i_far (.mclk(mclk), .line_in(pins.tx_pin),
    .oe(pins.data_oe), .d_out(pins.data_out), .line_out(far_line));

  // 100 ns clock
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    if (n_errors == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run

  // Compare and report
  task automatic chk(input string n, input logic [31:0] e, logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // Bounded wait for an edge with hready high
  task automatic ready_edge();
    int t;
    t = 0;
    do begin
      @(posedge mclk);
      t++;
    end while (hready !== 1'b1 && t < 50);
    if (hready !== 1'b1) begin
      n_errors++;
      complete_run();
    end
  endtask : ready_edge

  // One single word transfer
  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge mclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {27'h000_0000, a};
    hwrite <= w;
    ready_edge();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    ready_edge();
    r = hrdata;
  endtask : bus

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d, x);
  endtask : wr

  // Read, keep masked bits, compare
  task automatic rd(input string n, input logic [4:0] a,
                    input logic [31:0] e, input logic [31:0] m);
    bus(1'b0, a, 32'h0000_0000, x);
    chk(n, e, x & m);
  endtask : rd

  // Bounded wait for one interrupt line
  task automatic wait_irq(input int b);
    int t;
    t = 0;
    while (irq_vec[b] !== 1'b1 && t < 400) begin
      @(negedge mclk);
      t++;
    end
    if (irq_vec[b] !== 1'b1) begin
      n_errors++;
      complete_run();
    end
  endtask : wait_irq

  // A far-end wait that ran out ends the run
  task automatic far_check();
    if (i_far.lost) begin
      n_errors++;
      complete_run();
    end
  endtask : far_check

  ////////////////////////////////////////////////////////////////////
  // Main sequence, four cycles an async bit, eight a sync bit (reload 3)
  initial begin
    n_errors = 0;
    n_compared = 0;
    rst_b = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    chk("tx_pin", 32'h0000_0001, {31'h0, pins.tx_pin});
    chk("hresp", 32'h0000_0000, {31'h0, hresp});
    rd("ctrl", 5'h00, 32'h0000_0000, 32'hffff_ffff);
    rd("baud", 5'h04, 32'h0000_0000, 32'hffff_ffff);
    rd("stat", 5'h10, 32'h0000_0000, 32'hffff_ffff);
    rd("unmapped", 5'h18, 32'h0000_0000, 32'hffff_ffff);
    wr(5'h04, 32'h0000_0003);
    wr(5'h14, 32'h0000_003f);
    // Async transmit, eight bits
    wr(5'h00, 32'h0000_0301);
    wr(5'h08, 32'h0000_00a5);
    i_far.grab(10, 4, f);
    far_check();
    chk("frame8", 32'h0000_034a, {20'h0, f});
    wait_irq(0);
    chk("irq_vec", 32'h0000_0003, {28'h0, irq_vec});
    rd("stat", 5'h10, 32'h0000_0003, 32'hffff_ffff);
    // Nine bits, even parity, two stops
    wr(5'h00, 32'h0000_031d);
    wr(5'h08, 32'h0000_0007);
    i_far.grab(12, 4, f);
    far_check();
    chk("frame9", 32'h0000_0e0e, {20'h0, f});
    wait_irq(0);
    rd("stat", 5'h10, 32'h0000_0003, 32'hffff_ffff);
    // Nine bits, odd parity, one stop
    wr(5'h00, 32'h0000_0335);
    wr(5'h08, 32'h0000_0007);
    i_far.grab(11, 4, f);
    far_check();
    chk("frame_odd", 32'h0000_040e, {20'h0, f});
    wait_irq(0);
    rd("stat", 5'h10, 32'h0000_0003, 32'hffff_ffff);
    // Async receive
    wr(5'h00, 32'h0000_0301);
    i_far.send(12'h278, 10, 4);
    wait_irq(2);
    chk("irq_vec", 32'h0000_0004, {28'h0, irq_vec});
    rd("stat", 5'h10, 32'h0000_0004, 32'hffff_ffff);
    rd("rxd", 5'h0c, 32'h0000_023c, 32'hffff_ffff);
    // Overrun on an unread byte
    i_far.send(12'h222, 10, 4);
    i_far.send(12'h244, 10, 4);
    wait_irq(3);
    chk("irq_vec", 32'h0000_000c, {28'h0, irq_vec});
    rd("stat", 5'h10, 32'h0000_0024, 32'hffff_ffff);
    rd("rxd", 5'h0c, 32'h0000_0222, 32'hffff_ffff);
    chk("irq", 32'h0000_0000, {31'h0, irq});
    // Missing stop bit
    i_far.send(12'h0aa, 10, 4);
    wait_irq(3);
    rd("stat", 5'h10, 32'h0000_0010, 32'h0000_0038);
    bus(1'b0, 5'h0c, 32'h0000_0000, x);
    // Wrong parity bit
    wr(5'h00, 32'h0000_031d);
    i_far.send(12'hc0e, 12, 4);
    wait_irq(3);
    rd("stat", 5'h10, 32'h0000_0008, 32'h0000_0038);
    bus(1'b0, 5'h0c, 32'h0000_0000, x);
    // Wake-up mode drops data frames, keeps address frames
    wr(5'h00, 32'h0000_0245);
    i_far.send(12'h482, 11, 4);
    repeat (8) @(posedge mclk);
    rd("rxd", 5'h0c, 32'h0000_0000, 32'h0000_0200);
    i_far.send(12'h682, 11, 4);
    wait_irq(2);
    rd("rxd", 5'h0c, 32'h0000_0341, 32'hffff_ffff);
    rd("stat", 5'h10, 32'h0000_0004, 32'h0000_0004);
    // Loopback into the receiver
    wr(5'h00, 32'h0000_0381);
    wr(5'h08, 32'h0000_005a);
    wait_irq(2);
    rd("rxd", 5'h0c, 32'h0000_025a, 32'hffff_ffff);
    // Sync transmit with own shift clock
    wr(5'h00, 32'h0000_0003);
    wr(5'h08, 32'h0000_0096);
    i_far.grab_sync(f);
    far_check();
    chk("sync", 32'h0000_0196, {20'h0, f});
    rd("stat", 5'h10, 32'h0000_0007, 32'hffff_ffff);
    // Sync receive, shift clock still driven here
    wr(5'h00, 32'h0000_0203);
    wr(5'h08, 32'h0000_0000);
    i_far.send_sync(8'hc5);
    far_check();
    wait_irq(2);
    rd("rxd", 5'h0c, 32'h0000_02c5, 32'hffff_ffff);
    complete_run();
  end
endmodule : async_sync_serial_channel_tb
